// *** src/qwbs_seq.sv ***
// Purpose: Split a buffered 64-bit operand access into byte and word cycles on a 16-bit bus.
// Assumes: The bus side accepts a cycle when cyc_ready_i is high; other masters take the bus via gap_req_i.
// Notes: Only quad-word operands are handled here.
`timescale 1ns/10ps
module qwbs_seq
   import qwbs_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
)
(
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Operand requests.
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire qwbs_req_t req_i,
   // Gap request from prefetch or slave logic.
   input wire logic gap_req_i,
   output logic gap_grant_o,
   // Bus cycles.
   output logic cyc_valid_o,
   input wire logic cyc_ready_i,
   output qwbs_cycle_t cyc_o,
   output logic done_o
);
   typedef enum logic [1:0] {IDLE, RUN, GAP} qwbs_state_t;

   qwbs_state_t state_q, state_d;
   qwbs_req_t op_q, op_d, fifo_out;
   logic [2:0] step_q, step_d;
   logic odd_q, odd_d;
   qwbs_cycle_t cyc_q, cyc_d;
   logic done_q, done_d;
   logic f_valid, f_ready, last, half;

   ////////////////////////////////////////////////////////////////////////
   qwbs_fifo #(.WIDTH($bits(qwbs_req_t)), .DEPTH(DEPTH)) qwbs_fifo_i (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .in_valid_i(req_valid_i),
      .in_ready_o(req_ready_o),
      .in_data_i(req_i),
      .out_valid_o(f_valid),
      .out_ready_i(f_ready),
      .out_data_o(fifo_out)
   );

   // Build one bus cycle for a given step; byte index and address offset follow the lane pairing.
   function automatic qwbs_cycle_t make_cyc(input qwbs_req_t op, input logic odd, input logic [2:0] st);
      qwbs_cycle_t c;
      logic [2:0] off;
      c = '0;
      off = 3'h0;
      if (!odd)
      begin
         off = {st[1:0], 1'b0};
         c.high_lane_enable_n = 1'b0;
         c.low_lane_address_bit = 1'b0;
         c.low_lane = op.data[8*off +: 8];
         c.high_lane = op.data[8*(off+3'h1) +: 8];
      end
      else
      begin
         unique case (st)
            3'h0, 3'h3: off = {st[1:0] != 2'h0, 2'h0};
            3'h1, 3'h4: off = (st == 3'h1) ? 3'h1 : 3'h5;
            default: off = (st == 3'h2) ? 3'h3 : 3'h7;
         endcase
         c.high_lane_enable_n = (st == 3'h2 || st == 3'h5);
         c.low_lane_address_bit = (st == 3'h0 || st == 3'h3);
         if (c.low_lane_address_bit)
         begin
            c.high_lane = op.data[8*off +: 8];
         end
         else if (c.high_lane_enable_n)
         begin
            c.low_lane = op.data[8*off +: 8];
         end
         else
         begin
            c.low_lane = op.data[8*off +: 8];
            c.high_lane = op.data[8*(off+3'h1) +: 8];
         end
      end
      c.addr = op.addr + ADDR_W'(off);
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      state_d = state_q;
      op_d = op_q;
      step_d = step_q;
      odd_d = odd_q;
      cyc_d = cyc_q;
      done_d = 1'b0;
      f_ready = 1'b0;
      last = odd_q ? (step_q == LAST_ODD_STEP) : (step_q == LAST_EVEN_STEP);
      half = odd_q ? (step_q + 3'h1 == ODD_HALF_STEP) : (step_q + 3'h1 == EVEN_HALF_STEP);
      unique case (state_q)
         IDLE:
         begin
            f_ready = 1'b1;
            if (f_valid)
            begin
               op_d = fifo_out;
               odd_d = fifo_out.addr[0];
               step_d = 3'h0;
               cyc_d = make_cyc(fifo_out, fifo_out.addr[0], 3'h0);
               state_d = RUN;
            end
         end
         RUN:
         begin
            if (cyc_ready_i)
            begin
               if (last)
               begin
                  done_d = 1'b1;
                  state_d = IDLE;
               end
               else
               begin
                  step_d = step_q + 3'h1;
                  cyc_d = make_cyc(op_q, odd_q, step_q + 3'h1);
                  if (half && gap_req_i)
                  begin
                     state_d = GAP;
                  end
               end
            end
         end
         GAP:
         begin
            if (!gap_req_i)
            begin
               state_d = RUN;
            end
         end
         default: state_d = IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state_q <= IDLE;
         op_q <= '0;
         step_q <= 3'h0;
         odd_q <= 1'b0;
         cyc_q <= '0;
         done_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         op_q <= op_d;
         step_q <= step_d;
         odd_q <= odd_d;
         cyc_q <= cyc_d;
         done_q <= done_d;
      end
   end

   // Gap is only granted at the half boundary, so a foreign cycle never splits a half.
   assign gap_grant_o = (state_q == GAP);
   assign cyc_valid_o = (state_q == RUN);
   assign cyc_o = cyc_q;
   assign done_o = done_q;

   ////////////////////////////////////////////////////////////////////////
   even_lanes_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      cyc_valid_o && !odd_q |-> !cyc_o.high_lane_enable_n && !cyc_o.low_lane_address_bit)
      else $error("even sequence lane select wrong");
   even_addr_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      cyc_valid_o && !odd_q |-> cyc_o.addr == op_q.addr + ADDR_W'({step_q[1:0], 1'b0}))
      else $error("even sequence address wrong");
   even_bytes_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      cyc_valid_o && !odd_q && step_q == 3'h3 |-> cyc_o.low_lane == op_q.data[55:48]
      && cyc_o.high_lane == op_q.data[63:56])
      else $error("even last cycle bytes wrong");
   gap_place_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      $rose(gap_grant_o) |-> step_q == (odd_q ? ODD_HALF_STEP : EVEN_HALF_STEP))
      else $error("gap outside half boundary");
   odd_first_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      cyc_valid_o && odd_q && step_q == 3'h0 |-> cyc_o.low_lane_address_bit && cyc_o.high_lane == op_q.data[7:0])
      else $error("odd first cycle wrong");
   odd_second_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      cyc_valid_o && odd_q && step_q == 3'h4 |-> cyc_o.addr == op_q.addr + 24'h000005
      && cyc_o.low_lane == op_q.data[47:40] && cyc_o.high_lane == op_q.data[55:48])
      else $error("odd word at A+5 wrong");
   odd_last_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      cyc_valid_o && odd_q && step_q == 3'h5 |-> cyc_o.high_lane_enable_n && cyc_o.addr == op_q.addr + 24'h000007
      && cyc_o.low_lane == op_q.data[63:56])
      else $error("odd last cycle wrong");
   no_idle_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      cyc_valid_o && cyc_ready_i && !last && !(half && gap_req_i) |=> cyc_valid_o)
      else $error("idle state inside operand");
   align_pick_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      state_q == IDLE && f_valid |=> odd_q == $past(fifo_out.addr[0])
      && cyc_o.low_lane_address_bit == $past(fifo_out.addr[0]))
      else $error("sequence choice wrong");
   odd_third_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      cyc_valid_o && odd_q && step_q == 3'h2 |-> cyc_o.high_lane_enable_n && !cyc_o.low_lane_address_bit
      && cyc_o.addr == op_q.addr + 24'h000003 && cyc_o.low_lane == op_q.data[31:24])
      else $error("odd byte at A+3 wrong");
   gap_hold_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      gap_grant_o && gap_req_i |=> gap_grant_o && !cyc_valid_o)
      else $error("gap released while still wanted");
   gap_resume_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      gap_grant_o && !gap_req_i |=> cyc_valid_o)
      else $error("no cycle right after gap");
endmodule // qwbs_seq

// *** src/qwbs_pkg.sv ***
// Purpose: Shared constants and types for the quad-word bus access sequencer.
// Assumes: A 16-bit data bus split into two byte banks.
// Notes: Byte enable for the high lane is active low.
package qwbs_pkg;
   localparam int ADDR_W = 24;
   localparam int QW_BYTES = 8;
   localparam int FIFO_DEPTH = 16;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;
   localparam logic [63:0] DATA_RESET = 64'h0000000000000000;
   localparam logic [2:0] LAST_EVEN_STEP = 3'h3;
   localparam logic [2:0] LAST_ODD_STEP = 3'h5;
   localparam logic [2:0] ODD_HALF_STEP = 3'h3;
   localparam logic [2:0] EVEN_HALF_STEP = 3'h2;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [63:0] data;
   } qwbs_req_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic high_lane_enable_n;
      logic low_lane_address_bit;
      logic [7:0] high_lane;
      logic [7:0] low_lane;
   } qwbs_cycle_t;
endpackage

// *** src/qwbs_fifo.sv ***
// Purpose: Request buffer in front of the sequencer.
// Assumes: One clock, asynchronous active-high reset.
// Notes: Storage is flip-flops addressed by an index.
`timescale 1ns/10ps
module qwbs_fifo
   import qwbs_pkg::*;
#(
   parameter int WIDTH = 88,
   parameter int DEPTH = 16
)
(
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Filling side.
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Draining side.
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   always_comb
   begin
      push = in_valid_i && in_ready_o;
      pop = out_valid_o && out_ready_i;
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (push)
      begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = mem_q[rd_q];

   fifo_bound_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) cnt_q <= (AW+1)'(DEPTH))
      else $error("fifo count over depth");
endmodule // qwbs_fifo

// *** testbench/qwbs_bus_model.sv ***
// Purpose: Far-side model of the byte-banked 16-bit bus and of a prefetch unit that wants the bus.
// Assumes: Cycles are accepted whenever ready is high; stalls are random.
// Notes: The foreign request is held until three granted cycles pass, then rests until the operand ends.
`timescale 1ns/10ps
module qwbs_bus_model
   import qwbs_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Bench controls.
   input wire logic stall_i,
   input wire logic gap_en_i,
   // Sequencer side.
   input wire logic gap_grant_i,
   input wire logic done_i,
   output logic cyc_ready_o,
   output logic gap_req_o
);
   logic [1:0] grant_cnt_q;
   logic used_q;
   always @(posedge ref_clk_i or posedge reset_i)
      if (reset_i)
      begin
         cyc_ready_o <= 1'b0;
         gap_req_o <= 1'b0;
         grant_cnt_q <= 2'h0;
         used_q <= 1'b0;
      end
      else
      begin
         // Random stalls show that a presented cycle stands until taken.
         cyc_ready_o <= !stall_i && ($urandom_range(3) != 0);
         if (done_i)
         begin
            used_q <= 1'b0;
            grant_cnt_q <= 2'h0;
         end
         else if (gap_grant_i)
         begin
            grant_cnt_q <= grant_cnt_q + 2'h1;
            if (grant_cnt_q == 2'h2)
            begin
               gap_req_o <= 1'b0;
               grant_cnt_q <= 2'h0;
               used_q <= 1'b1;
            end
         end
         else if (gap_en_i && !used_q)
            gap_req_o <= 1'b1;
      end
endmodule // qwbs_bus_model

// *** testbench/qwbs_seq_tb.sv ***
// Purpose: Self-checking bench for the quad-word sequencer.
// Assumes: The bus model stalls at random and asks for the gap.
// Notes: A driver queues expected cycles; a monitor compares them as they are taken.
`timescale 1ns/10ps
module qwbs_seq_tb;
   import qwbs_pkg::*;
   typedef struct packed {qwbs_cycle_t c; logic half; logic last;} qwbs_exp_t;
   logic ref_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic req_valid_i = 1'b0;
   qwbs_req_t req_i = '0;
   logic req_ready_o, gap_req_i, gap_grant_o, cyc_valid_o, cyc_ready_i, done_o;
   logic stall = 1'b0;
   logic gap_en = 1'b0;
   logic pend_next = 1'b0;
   logic pend_done = 1'b0;
   logic last_half = 1'b0;
   logic gap_prev = 1'b0;
   logic gap_due = 1'b0;
   qwbs_cycle_t cyc_o;
   qwbs_exp_t exq[$];
   int failures = 0;
   int compares = 0;
   int grants = 0;
   int cycles = 0;
   int n;
   bit ok;
   always #10 ref_clk_i = ~ref_clk_i;
   qwbs_seq qwbs_seq_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
      .req_ready_o(req_ready_o), .req_i(req_i), .gap_req_i(gap_req_i), .gap_grant_o(gap_grant_o),
      .cyc_valid_o(cyc_valid_o), .cyc_ready_i(cyc_ready_i), .cyc_o(cyc_o), .done_o(done_o));
   qwbs_bus_model qwbs_bus_model_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .stall_i(stall),
      .gap_en_i(gap_en), .gap_grant_i(gap_grant_o), .done_i(done_o), .cyc_ready_o(cyc_ready_i),
      .gap_req_o(gap_req_i));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   function automatic qwbs_exp_t mk(input logic [23:0] a, input logic [1:0] en, input logic [7:0] hi,
      input logic [7:0] lo, input logic [1:0] hl);
      return '{c: '{a, en[1], en[0], hi, lo}, half: hl[1], last: hl[0]};
   endfunction
   // Expected cycles are queued only once the request is taken.
   task automatic send(input logic [23:0] a, input logic [63:0] d, output bit acc);
      logic [7:0] b[8];
      acc = 0;
      for (int k = 0; k < 8; k++)
         b[k] = d[8*k +: 8];
      req_valid_i <= 1'b1;
      req_i <= '{a, d};
      for (int w = 0; w < 40 && !acc; w++)
      begin
         @(posedge ref_clk_i);
         acc = req_ready_o;
      end
      req_valid_i <= 1'b0;
      if (acc && !a[0])
         for (int k = 0; k < 8; k += 2)
            exq.push_back(mk(a + 24'(k), 2'h0, b[k+1], b[k], {k == 2, k == 6}));
      else if (acc)
      begin
         exq.push_back(mk(a, 2'h1, b[0], 8'h00, 2'h0));
         exq.push_back(mk(a + 24'h1, 2'h0, b[2], b[1], 2'h0));
         exq.push_back(mk(a + 24'h3, 2'h2, 8'h00, b[3], 2'h2));
         exq.push_back(mk(a + 24'h4, 2'h1, b[4], 8'h00, 2'h0));
         exq.push_back(mk(a + 24'h5, 2'h0, b[6], b[5], 2'h0));
         exq.push_back(mk(a + 24'h7, 2'h2, 8'h00, b[7], 2'h1));
      end
      @(posedge ref_clk_i);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // The monitor reads values from before each edge, as the design saw them.
   always @(posedge ref_clk_i)
      if (!reset_i)
      begin
         qwbs_exp_t e;
         if (pend_next && !gap_prev)
         begin
            check(cyc_valid_o | gap_grant_o, 1);
            check(gap_grant_o, gap_due);
         end
         check(done_o, pend_done);
         pend_done = 0;
         if (gap_grant_o && !gap_prev)
         begin
            grants++;
            check(last_half, 1);
         end
         gap_prev = gap_grant_o;
         if (cyc_valid_o)
            pend_next = 0;
         if (cyc_valid_o && cyc_ready_i)
         begin
            e = exq.size() ? exq.pop_front() : '0;
            check(cyc_o, e.c);
            pend_next = !e.last;
            pend_done = e.last;
            last_half = e.half;
            gap_due = e.half && gap_req_i;
         end
      end
   always @(posedge ref_clk_i)
      if (++cycles == 20000)
      begin
         failures++;
         report_and_stop();
      end
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(88251));
      repeat (10) @(posedge ref_clk_i);
      check({req_ready_o, cyc_valid_o, done_o, gap_grant_o}, 4'h8);
      reset_i <= 1'b0;
      @(posedge ref_clk_i);
      gap_en <= 1'b1;
      for (int i = 0; i < 40; i++)
      begin
         send(24'($urandom) & 24'hfffff0 | 24'(i[0]), {$urandom, $urandom}, ok);
         repeat ($urandom_range(12)) @(posedge ref_clk_i);
      end
      // Drain first, so that the fill below holds one operand in the sequencer and a full buffer.
      for (int w = 0; w < 3000 && exq.size() > 0; w++)
         @(posedge ref_clk_i);
      repeat (2) @(posedge ref_clk_i);
      // Fill the buffer against a stalled bus until it refuses.
      stall <= 1'b1;
      n = 0;
      ok = 1;
      while (ok && n < 20)
      begin
         send(24'($urandom) & 24'hfffff0 | 24'(n[0]), {$urandom, $urandom}, ok);
         n += ok;
      end
      check(n, FIFO_DEPTH + 1);
      check(req_ready_o, 0);
      stall <= 1'b0;
      for (int w = 0; w < 3000 && exq.size() > 0; w++)
         @(posedge ref_clk_i);
      repeat (4) @(posedge ref_clk_i);
      check(exq.size(), 0);
      check(grants > 0, 1);
      report_and_stop();
   end
endmodule // qwbs_seq_tb
